/* rtl/sti_defs.svh */
// Constants for the safe torque interlock: offsets, bit positions, timing
`ifndef STI_DEFS_SVH
`define STI_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define STI_CLK_KHZ       20000
`define STI_FLASH_MS      2000
`define STI_FLASH_CYC     (`STI_FLASH_MS * `STI_CLK_KHZ)
`define STI_FLASH_DIV     10
`define STI_CHECK_US      10
`define STI_CHECK_CYC     (`STI_CHECK_US * `STI_CLK_KHZ / 1000)

// ----------------------------------------------------------------
// Analog scaling, 12-bit converter over 0 to 5 V
// ----------------------------------------------------------------
`define STI_FS_MV         5000
`define STI_ADC_FS        4096
`define STI_MV2CODE(mv)   ((mv) * `STI_ADC_FS / `STI_FS_MV)
`define STI_ANA_LO_MV     250
`define STI_ANA_HI_MV     4750
`define STI_MID_MV        2500
`define STI_DB_MV         50
`define STI_PRIO_ANA_MIN  2'h2

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define STI_ADDR_CTRL     8'h00
`define STI_ADDR_STAT     8'h04
`define STI_ADDR_ISTAT    8'h08
`define STI_ADDR_IMASK    8'h0c
`define STI_ADDR_ANGLE    8'h10
`define STI_ADDR_ACMD     8'h14
`define STI_CTRL_DRV      0
`define STI_CTRL_SAFE     1
`define STI_CTRL_PRIO     2
`define STI_PRIO_W        2
`define STI_SAFE_RST      1'b1
`define STI_IRQ_W         4
`define STI_IRQ_FAULT     0
`define STI_IRQ_CHECK     1
`define STI_IRQ_HALL      2
`define STI_IRQ_ANA       3

`endif

/* rtl/sti_pkg.sv */
// Types shared by the safe torque interlock and its bench
package sti_pkg;

   // ----------------------------------------------------------------
   // Self-check states, Gray along idle, test, pass
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CK_IDLE = 2'h0,
      CK_TEST = 2'h1,
      CK_PASS = 2'h3,
      CK_FAIL = 2'h2
   } sti_chk_e;

   // Bridge drive: bit 0 winding U, bit 1 V, bit 2 W
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } sti_gate_s;

   // ----------------------------------------------------------------
   // Whole state of the interlock
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        strap_done;
      logic        tq_en;
      sti_chk_e    st;
      logic [15:0] cnt;
      logic        both_q;
      logic        running;
      logic        drv;
      logic        safe;
      logic [1:0]  prio;
      logic [3:0]  istat;
      logic [3:0]  imask;
      logic [31:0] rdata;
      logic        err;
      sti_gate_s   gate;
      logic [1:0]  user_in;
      logic        led;
      logic [31:0] led_cnt;
      logic [12:0] sin_v;
      logic [12:0] cos_v;
      logic [12:0] ana_v;
   } sti_state_s;

endpackage

/* rtl/sti_interlock.sv */
// Safe torque interlock with Hall commutation and APB registers
//
// How it works
// - Enabled guard turns both inputs into channels
// - Switches energized only with both channels high
// - Self-check at power-up and each both-high rise
// - Either channel low disables the outputs
// - Single high channel disables and flags fault
// - Guard off unless jumper strap is removed
// - Analog command counts only at priority two/three
// - Analog start needs center and 0.25-4.75 V
// - Status light flashes on a two-second cycle
// - Sine and cosine are signed about 2.5 V
// - Three Hall signals select the active windings
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "sti_defs.svh"

module sti_interlock
   import sti_pkg::*;
#(
   parameter int unsigned FLASH_CYC = `STI_FLASH_CYC,
   parameter logic [12:0] DEADBAND  = 13'(`STI_MV2CODE(`STI_DB_MV))
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        digital_in_one,
   input  wire logic        digital_in_two,
   input  wire logic        strap_fitted,
   input  wire logic        check_echo,
   input  wire logic [2:0]  hall,
   input  wire logic [11:0] analog_cmd,
   input  wire logic [11:0] sine_angle_input,
   input  wire logic [11:0] cosine_angle_input,
   output logic             check_pulse,
   output sti_gate_s        gate,
   output logic [1:0]       user_in,
   output logic signed [12:0] sin_value,
   output logic signed [12:0] cos_value,
   output logic             status_led,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Derived constants
   // ----------------------------------------------------------------
   localparam logic [12:0] ANA_LO  = 13'(`STI_MV2CODE(`STI_ANA_LO_MV));
   localparam logic [12:0] ANA_HI  = 13'(`STI_MV2CODE(`STI_ANA_HI_MV));
   localparam logic [12:0] MID     = 13'(`STI_MV2CODE(`STI_MID_MV));
   localparam logic [15:0] CHK_END = 16'(`STI_CHECK_CYC - 1);
   localparam logic [31:0] FL_END  = 32'(FLASH_CYC - 1);
   localparam logic [31:0] FL_ON   = 32'(FLASH_CYC / `STI_FLASH_DIV);

   sti_state_s s;
   sti_state_s n;

   logic       both_hi;
   logic       one_hi;
   logic       rise;
   logic       tq_ok;
   logic       hall_ok;
   logic       ana_on;
   logic [12:0] ana_code;
   logic       in_range;
   logic       centered;
   logic       ana_bad;
   logic       ana_block;
   logic       want;
   logic       setup;
   logic       wr;
   logic [3:0] ev;
   logic [3:0] clr;
   logic       fault_show;

   // ----------------------------------------------------------------
   // Six-step commutation table
   // ----------------------------------------------------------------
   // Codes 000 and 111 cannot occur with 120 degree sensors,
   // so they mean a broken wire and drive nothing
   function automatic sti_gate_s drive_of(input logic [2:0] h);
      sti_gate_s g;
      g = '0;
      unique case (h)
         3'h5: begin
            g.hi = 3'h1;
            g.lo = 3'h2;
         end
         3'h4: begin
            g.hi = 3'h1;
            g.lo = 3'h4;
         end
         3'h6: begin
            g.hi = 3'h2;
            g.lo = 3'h4;
         end
         3'h2: begin
            g.hi = 3'h2;
            g.lo = 3'h1;
         end
         3'h3: begin
            g.hi = 3'h4;
            g.lo = 3'h1;
         end
         3'h1: begin
            g.hi = 3'h4;
            g.lo = 3'h2;
         end
         default: g = '0;
      endcase
      return g;
   endfunction

   // ----------------------------------------------------------------
   // Channel and sensor decode
   // ----------------------------------------------------------------
   // Inputs come already thresholded: high means 6 to 30 V
   assign both_hi = digital_in_one & digital_in_two;
   assign one_hi  = digital_in_one ^ digital_in_two;
   assign rise    = both_hi & !s.both_q;
   // Off-guard drives freely; on-guard needs both high and a pass
   assign tq_ok   = !s.tq_en | (both_hi & (s.st == CK_PASS));
   assign hall_ok = (hall != 3'h0) && (hall != 3'h7);

   // Analog gating
   assign ana_on    = s.prio >= `STI_PRIO_ANA_MIN;
   assign ana_code  = {1'b0, analog_cmd};
   assign in_range  = (ana_code >= ANA_LO) && (ana_code <= ANA_HI);
   assign centered  = ($signed(s.ana_v) <= $signed(DEADBAND)) &&
                      ($signed(s.ana_v) >= -$signed(DEADBAND));
   assign ana_bad   = ana_on & s.safe & !in_range;
   assign ana_block = ana_on & s.safe & !(in_range & centered);
   assign want      = s.drv & tq_ok & hall_ok;

   // APB phases
   assign setup = psel & !penable;
   assign wr    = psel & penable & pwrite;
   assign clr   = (wr && paddr == `STI_ADDR_ISTAT) ? pwdata[3:0] : 4'h0;

   // Exception pattern shown while anything needs attention
   assign fault_show = (|s.istat) | (s.st == CK_FAIL) | (s.tq_en & one_hi);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      n  = s;
      ev = 4'h0;

      // Strap sampled once, the first edge after reset release
      if (!s.strap_done) begin
         n.strap_done = 1'b1;
         n.tq_en      = !strap_fitted;
      end
      n.both_q = both_hi;

      // Channels double as user inputs only with guard off
      // Held at zero until the strap is known, so nothing leaks on the first edge
      n.user_in = (s.tq_en | !s.strap_done) ? 2'h0 : {digital_in_two, digital_in_one};

      // Single-channel fault is a level, so it re-arms until cleared
      ev[`STI_IRQ_FAULT] = s.tq_en & one_hi;

      // Self-check sequencer; reset lands in test for power-up
      unique case (s.st)
         CK_IDLE: begin
            if (rise) begin
               n.st  = CK_TEST;
               n.cnt = 16'h0;
            end
         end
         CK_TEST: begin
            n.cnt = s.cnt + 16'h1;
            if (s.cnt == CHK_END) begin
               // Echo must read blocked while the test pulse is on
               n.st = check_echo ? CK_FAIL : CK_PASS;
               ev[`STI_IRQ_CHECK] = check_echo;
            end
         end
         CK_PASS: begin
            if (s.tq_en & !both_hi) begin
               n.st = CK_IDLE;
            end
         end
         CK_FAIL: begin
            if (s.tq_en & !both_hi) begin
               n.st = CK_IDLE;
            end
         end
      endcase

      // Run latch: analog center needed only to start
      if (!s.running) begin
         if (want & !ana_block) begin
            n.running = 1'b1;
         end
         ev[`STI_IRQ_ANA] = want & ana_block;
      end else if (!want | ana_bad) begin
         n.running = 1'b0;
         ev[`STI_IRQ_ANA] = ana_bad;
      end
      ev[`STI_IRQ_HALL] = s.drv & !hall_ok;

      // Bridge drive from the Hall state
      n.gate = (n.running && s.st != CK_TEST) ? drive_of(hall) : '0;

      // Signed views about midscale
      n.sin_v = {1'b0, sine_angle_input} - MID;
      n.cos_v = {1'b0, cosine_angle_input} - MID;
      n.ana_v = ana_code - MID;

      // Flash cadence; second blink marks an exception
      n.led_cnt = (s.led_cnt >= FL_END) ? 32'h0 : s.led_cnt + 32'h1;
      n.led = (s.led_cnt < FL_ON) |
              (fault_show & (s.led_cnt >= 2 * FL_ON) &
               (s.led_cnt < 3 * FL_ON));

      // Register writes land in the access phase
      if (wr) begin
         unique case (paddr)
            `STI_ADDR_CTRL: begin
               n.drv  = pwdata[`STI_CTRL_DRV];
               n.safe = pwdata[`STI_CTRL_SAFE];
               n.prio = pwdata[`STI_CTRL_PRIO +: `STI_PRIO_W];
            end
            `STI_ADDR_IMASK: n.imask = pwdata[3:0];
            default: n.imask = s.imask;
         endcase
      end
      // Set beats clear in the same cycle
      n.istat = (s.istat & ~clr) | ev;

      // Read data and error prepared in the setup phase
      if (setup) begin
         n.err   = 1'b0;
         n.rdata = 32'h0;
         unique case (paddr)
            `STI_ADDR_CTRL:
               n.rdata = 32'({s.prio, s.safe, s.drv});
            `STI_ADDR_STAT:
               n.rdata = 32'({s.st, hall, in_range, centered, s.running,
                              digital_in_two, digital_in_one, s.tq_en});
            `STI_ADDR_ISTAT: n.rdata = 32'(s.istat);
            `STI_ADDR_IMASK: n.rdata = 32'(s.imask);
            `STI_ADDR_ANGLE:
               n.rdata = {3'h0, s.cos_v, 3'h0, s.sin_v};
            `STI_ADDR_ACMD:  n.rdata = 32'(s.ana_v);
            default:         n.err   = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s         <= '0;
         s.st      <= CK_TEST;
         s.safe    <= `STI_SAFE_RST;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Zero wait states: every access completes in one access cycle
   assign pready      = 1'b1;
   assign prdata      = s.rdata;
   assign pslverr     = s.err;
   assign check_pulse = s.st == CK_TEST;
   assign gate        = s.gate;
   assign user_in     = s.user_in;
   assign sin_value   = $signed(s.sin_v);
   assign cos_value   = $signed(s.cos_v);
   assign status_led  = s.led;
   assign irq         = |(s.istat & s.imask);

endmodule

/* testbench/sti_interlock_asserts.sv */
// Port checker for the safe torque interlock
`timescale 1ns/1ps
module sti_interlock_asserts
   import sti_pkg::*;
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic [7:0]         paddr,
   input wire logic               pslverr,
   input wire logic               digital_in_one,
   input wire logic               digital_in_two,
   input wire logic               strap_fitted,
   input wire logic [2:0]         hall,
   input wire logic [11:0]        sine_angle_input,
   input wire logic signed [12:0] sin_value,
   input wire logic               check_pulse,
   input wire sti_gate_s          gate,
   input wire logic [1:0]         user_in
);
   // ------
   // Guard sequences, strap held out
   // ------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence guard_open;
      !strap_fitted && !(digital_in_one && digital_in_two);
   endsequence
   sequence both_rise;
      !strap_fitted && $rose(digital_in_one && digital_in_two);
   endsequence

   // Gate outputs follow the guard one edge late
   chan_off_a: assert property (guard_open |=> gate == 6'h0)
      else $error("gate on with a channel low");
   pair_need_a: assert property (presetn && gate != 6'h0 && !strap_fitted |-> $past(digital_in_one && digital_in_two))
      else $error("gate on without both channels");
   check_off_a: assert property (check_pulse |-> gate == 6'h0)
      else $error("gate on during self-check");
   check_go_a: assert property (both_rise |-> ##[1:3] check_pulse)
      else $error("no self-check on both-high");
   check_hold_a: assert property ($rose(check_pulse) |=> check_pulse [*8])
      else $error("self-check cut short");
   // Commutation table spot check and bridge shoot-through
   hall_bad_a: assert property (hall == 3'h0 || hall == 3'h7 |=> gate == 6'h0)
      else $error("gate on with invalid hall");
   hall_map_a: assert property (presetn && gate == 6'h0a |-> $past(hall) == 3'h5)
      else $error("U to V drive from wrong hall");
   gate_excl_a: assert property ((gate.hi & gate.lo) == 3'h0 && $onehot0(gate.hi) && $onehot0(gate.lo))
      else $error("illegal winding pair");
   user_hide_a: assert property (!strap_fitted |-> user_in == 2'h0)
      else $error("user inputs leak with guard on");
   sin_mid_a: assert property (presetn |=> sin_value == 13'($past(sine_angle_input)) - 13'h800)
      else $error("sine not centred at midscale");
   bad_addr_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
      else $error("unmapped access without error");
endmodule

bind sti_interlock sti_interlock_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .digital_in_one(digital_in_one), .digital_in_two(digital_in_two),
   .strap_fitted(strap_fitted), .hall(hall), .sine_angle_input(sine_angle_input),
   .sin_value(sin_value), .check_pulse(check_pulse), .gate(gate), .user_in(user_in));

/* testbench/sti_field.sv */
// Model of the safety wiring, Hall sensors and power-enable readback
`timescale 1ns/1ps
module sti_field (
   input  wire logic pclk,
   input  wire logic check_pulse,
   output logic      chan_a,
   output logic      chan_b,
   output logic [2:0] hall,
   output logic      check_echo
);
   // Healthy chain: echo drops while the self-check cuts power
   assign check_echo = !check_pulse;
   initial begin
      chan_a = 1'b0;
      chan_b = 1'b0;
      hall = 3'h5;
   end
   // Wiring changes just after an edge
   task automatic set_in(input logic a, input logic b, input logic [2:0] h);
      @(posedge pclk);
      chan_a <= a;
      chan_b <= b;
      hall <= h;
   endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the safe torque interlock
`timescale 1ns/1ps
module tb_top
   import sti_pkg::*;
;
   // ------
   // Signals and the block
   // ------
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, ch_a, ch_b, echo, chk_on, led, irq, e;
   logic [2:0]  hall;
   logic [11:0] acmd = 12'h800, sin_in = 12'h900, cos_in = 12'h700;
   logic [1:0]  uin;
   logic        strap = 1'b0;
   logic [12:0] sin_v, cos_v;
   sti_gate_s   gate;
   int          n_fail = 0, num_checks = 0, i;
   localparam logic [2:0] hall_seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   localparam logic [5:0] gate_seq [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};

   always #25 pclk = ~pclk;
   sti_interlock #(.FLASH_CYC(100)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .digital_in_one(ch_a), .digital_in_two(ch_b), .strap_fitted(strap), .check_echo(echo), .hall(hall),
      .analog_cmd(acmd), .sine_angle_input(sin_in), .cosine_angle_input(cos_in), .check_pulse(chk_on),
      .gate(gate), .user_in(uin), .sin_value(sin_v), .cos_value(cos_v), .status_led(led), .irq(irq));
   sti_field fld (.pclk(pclk), .check_pulse(chk_on), .chan_a(ch_a), .chan_b(ch_b), .hall(hall),
      .check_echo(echo));

   // ------
   // Shared tasks
   // ------
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Setup then access; the wait on pready is bounded
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         final_report;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic gchk(input logic [5:0] x);
      chk({26'h0, gate}, {26'h0, x});
   endtask
   // Polls until the self-check has left test, then judges the settled state
   task automatic wait_pass(input logic [1:0] x);
      int k;
      for (k = 0; k < 120; k++) begin
         apb(1'b0, 8'h04, 32'h0);
         if (q[10:9] !== 2'b01) break;
      end
      chk({30'h0, q[10:9]}, {30'h0, x});
      if (k == 120) final_report;
   endtask
   task automatic set_cmd(input logic [11:0] v);
      @(posedge pclk);
      acmd <= v;
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_power;
      rd(8'h00, 32'hf, 32'h2);
      // Channels are low, so a passed power-up check falls back to idle
      wait_pass(2'b00);
      rd(8'h08, 32'h2, 32'h0);
      rd(8'h04, 32'h7cf, 32'h141);
      rd(8'h10, 32'h1fff_1fff, 32'h1f00_0100);
      chk({19'h0, cos_v}, {19'h0, 13'h1f00});
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
   endtask
   // Single channel fault raised, masked, unmasked, cleared
   task automatic t_single;
      apb(1'b1, 8'h0c, 32'h0);
      fld.set_in(1'b1, 1'b0, 3'h5);
      cyc(4);
      gchk(6'h00);
      rd(8'h08, 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h0c, 32'h1);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      fld.set_in(1'b0, 1'b0, 3'h5);
      apb(1'b1, 8'h08, 32'h1);
      rd(8'h08, 32'hf, 32'h0);
      cyc(1);
      chk({31'h0, irq}, 32'h0);
   endtask
   // One flash per period when clean, an extra one on a fault
   task automatic led_rises(input int exp);
      int n;
      logic p;
      n = 0;
      p = led;
      repeat (100) begin
         @(negedge pclk);
         if (led && !p) n++;
         p = led;
      end
      chk(32'(n), 32'(exp));
   endtask
   task automatic t_led;
      led_rises(1);
      fld.set_in(1'b1, 1'b0, 3'h5);
      led_rises(2);
      fld.set_in(1'b0, 1'b0, 3'h5);
      apb(1'b1, 8'h08, 32'hf);
   endtask
   task automatic t_drive;
      apb(1'b1, 8'h00, 32'h1);
      fld.set_in(1'b1, 1'b1, 3'h5);
      cyc(3);
      chk({31'h0, chk_on}, 32'h1);
      wait_pass(2'b11);
      cyc(2);
      gchk(6'h0a);
      for (i = 0; i < 6; i++) begin
         fld.set_in(1'b1, 1'b1, hall_seq[i]);
         cyc(2);
         gchk(gate_seq[i]);
      end
      for (i = 0; i < 2; i++) begin
         fld.set_in(1'b1, 1'b1, i == 0 ? 3'h0 : 3'h7);
         cyc(2);
         gchk(6'h00);
      end
      // Running again first, so the channel drop really has to stop it
      fld.set_in(1'b1, 1'b1, 3'h5);
      cyc(2);
      gchk(6'h0a);
      fld.set_in(1'b0, 1'b1, 3'h5);
      cyc(2);
      gchk(6'h00);
      fld.set_in(1'b1, 1'b1, 3'h5);
      cyc(3);
      chk({31'h0, chk_on}, 32'h1);
      wait_pass(2'b11);
      // Analog at priority 1 is ignored, at 2 it gates the start, at 3 an out-of-range command stops the drive
      set_cmd(12'h100);
      apb(1'b1, 8'h00, 32'h7);
      cyc(2);
      gchk(6'h0a);
      // Centering only blocks a start, so stop the drive in the same write that enables analog
      apb(1'b1, 8'h00, 32'ha);
      apb(1'b1, 8'h00, 32'hb);
      cyc(2);
      gchk(6'h00);
      rd(8'h08, 32'h8, 32'h8);
      set_cmd(12'h830);
      cyc(3);
      gchk(6'h00);
      set_cmd(12'h820);
      cyc(3);
      gchk(6'h0a);
      apb(1'b1, 8'h00, 32'hf);
      set_cmd(12'hfff);
      cyc(2);
      gchk(6'h00);
   endtask
   // Mid-run reset with the strap fitted: guard off, channels are user inputs
   task automatic t_strap;
      @(posedge pclk);
      strap <= 1'b1;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      fld.set_in(1'b1, 1'b0, 3'h5);
      apb(1'b1, 8'h00, 32'h1);
      wait_pass(2'b11);
      cyc(2);
      gchk(6'h0a);
      chk({30'h0, uin}, 32'h1);
      rd(8'h08, 32'h1, 32'h0);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_power;
      t_single;
      t_led;
      t_drive;
      t_strap;
      final_report;
   end
endmodule
